// ==== inc/ptpf_regs.vh ====
/*
  Register offsets, field positions, reset values and encodings for the
  per-port PTP receive filter and pending timestamp counter.
  Assumes a 9-bit byte address space and one 32-bit word per register.
*/
// Summary of operation
// (RL1) Capture info bits 6:4 show read-only 3-bit transmit pending count.
// (RL2) Transmit count up on each sent PTP packet, down on acknowledge write.
// (RL3) Capture info bits 2:0 show read-only 3-bit receive pending count.
// (RL4) Receive count up on each received PTP packet, down on acknowledge.
// (RL5) Capture info is read-only, bits 31:7 and 3 reserved, counts reset zero.
// (RL6) Bank select (3 bits) and port select (2 bits) steer register accesses.
// (RL7) Bit 14 accepts layer 2 multicast 01:80:C2:00:00:0E, resets one.
// (RL8) Bit 13 accepts layer 2 address 01:1B:19:00:00:00, resets one.
// (RL9) Bit 12 accepts group ...01:81 / 224.0.1.129 / FF0X::181, resets one.
// (RL10) Bit 11 accepts group ...01:82 / 224.0.1.130 / FF0X::182, resets zero.
// (RL11) Bit 10 accepts group ...01:83 / 224.0.1.131 / FF0X::183, resets zero.
// (RL12) Bit 9 accepts group ...01:84 / 224.0.1.132 / FF0X::184, resets zero.
// (RL13) Bit 8 accepts ...00:6B / 224.0.0.107 / FF02::6B, resets one.
// (RL14) Bit 7 accepts the software-defined address for layer 2 frames.
// (RL15) Bit 6 accepts the software-defined address for UDP over IPv6.
// (RL16) Bit 5 accepts the software-defined address for UDP over IPv4.
// (RL17) Software changes parse bits only while the timestamp unit is off.
// (RL18) Bits 4 and 3 enable IP and MAC destination checking, reset one.
// (RL19) Bits 2, 1, 0 enable layer 2, IPv6, IPv4 detection, reset one.
// (RL20) With checking on, destination must match an enabled address.
`ifndef PTPF_REGS_VH
`define PTPF_REGS_VH

// Register byte offsets
`define PTPF_OFF_CUSTOM_HIGH 9'h120
`define PTPF_OFF_CUSTOM_LOW 9'h124
`define PTPF_OFF_STAMP_ACK 9'h128
`define PTPF_OFF_BANK_PORT 9'h154
`define PTPF_OFF_PARSE 9'h158
`define PTPF_OFF_CAP_INFO 9'h160

// Banks
`define PTPF_BANK_CAP 3'h0
`define PTPF_BANK_PARSE 3'h1

// Bank and port select fields
`define PTPF_BANK_LSB 0
`define PTPF_BANK_MSB 2
`define PTPF_PORT_LSB 4
`define PTPF_PORT_MSB 5

// Capture info and acknowledge fields
`define PTPF_RX_CNT_LSB 0
`define PTPF_RX_CNT_MSB 2
`define PTPF_TX_CNT_LSB 4
`define PTPF_TX_CNT_MSB 6
`define PTPF_CNT_MAX 3'h7
`define PTPF_CNT_RESET 3'h0

// Parse configuration fields
`define PTPF_P_V4_DET 0
`define PTPF_P_V6_DET 1
`define PTPF_P_L2_DET 2
`define PTPF_P_MAC_CHK 3
`define PTPF_P_IP_CHK 4
`define PTPF_P_V4_CUSTOM 5
`define PTPF_P_V6_CUSTOM 6
`define PTPF_P_L2_CUSTOM 7
`define PTPF_P_GROUP5 8
`define PTPF_P_GROUP1 12
`define PTPF_P_L2_B 13
`define PTPF_P_L2_A 14
`define PTPF_PARSE_MSB 14
`define PTPF_PARSE_RESET 15'h711f

// Frame format codes from the frame path
`define PTPF_FMT_NONE 2'h0
`define PTPF_FMT_L2 2'h1
`define PTPF_FMT_V4 2'h2
`define PTPF_FMT_V6 2'h3

// Well-known destination addresses
`define PTPF_MAC_L2_A 48'h0180c200000e
`define PTPF_MAC_L2_B 48'h011b19000000
`define PTPF_MAC_V4_PFX 24'h01005e
`define PTPF_MAC_V6_PFX 16'h3333
`define PTPF_V4_PFX 16'he000
`define PTPF_V6_GRP_TOP 8'hff
`define PTPF_V6_LINK 16'hff02
`define PTPF_GRP_BASE 8'h81
`define PTPF_GRP5_LOW 8'h6b

`endif

// ==== rtl/ptpf_dest_match.v ====
/*
  Destination matcher: decides whether one received frame qualifies as a
  PTP message from its format, destination MAC and destination IP.
  Assumes the caller hands in the parse configuration of the frame's port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptpf_regs.vh"

module ptpf_dest_match (
  input wire [14:0] cfg,
  input wire [1:0] format,
  input wire [47:0] dest_mac,
  input wire [127:0] dest_ip,
  input wire [47:0] custom_mac,
  output reg match
);

  reg l2_hit;
  reg v4_mac_hit;
  reg v6_mac_hit;
  reg v4_ip_hit;
  reg v6_ip_hit;
  reg mac_hit;
  reg ip_hit;
  reg fmt_on;
  reg [7:0] grp;
  integer k;

  // Address compare against every enabled destination
  always @* begin
    l2_hit = (cfg[`PTPF_P_L2_A] && dest_mac == `PTPF_MAC_L2_A) || // [RL7]
      (cfg[`PTPF_P_L2_B] && dest_mac == `PTPF_MAC_L2_B) || // [RL8]
      (cfg[`PTPF_P_L2_CUSTOM] && dest_mac == custom_mac); // [RL14]
    v4_mac_hit = cfg[`PTPF_P_V4_CUSTOM] && dest_mac == custom_mac; // [RL16]
    v6_mac_hit = cfg[`PTPF_P_V6_CUSTOM] && dest_mac == custom_mac; // [RL15]
    v4_ip_hit = 1'b0;
    v6_ip_hit = 1'b0;
    grp = 8'h00;
    // Groups 1 to 4 differ only in the last address byte
    for (k = 0; k < 4; k = k + 1) begin
      grp = `PTPF_GRP_BASE + k[7:0];
      if (cfg[`PTPF_P_GROUP1 - k]) begin // [RL9] [RL10] [RL11] [RL12]
        if (dest_mac == {`PTPF_MAC_V4_PFX, 16'h0001, grp})
          v4_mac_hit = 1'b1;
        if (dest_mac == {`PTPF_MAC_V6_PFX, 24'h000001, grp})
          v6_mac_hit = 1'b1;
        if (dest_ip[31:0] == {`PTPF_V4_PFX, 8'h01, grp})
          v4_ip_hit = 1'b1;
        if (dest_ip[127:120] == `PTPF_V6_GRP_TOP &&
            dest_ip[119:116] == 4'h0 &&
            dest_ip[111:0] == {96'h0, 8'h01, grp})
          v6_ip_hit = 1'b1;
      end
    end
    // Group 5 uses the link-local scope only on IPv6
    if (cfg[`PTPF_P_GROUP5]) begin // [RL13]
      if (dest_mac == {`PTPF_MAC_V4_PFX, 16'h0000, `PTPF_GRP5_LOW})
        v4_mac_hit = 1'b1;
      if (dest_mac == {`PTPF_MAC_V6_PFX, 24'h000000, `PTPF_GRP5_LOW})
        v6_mac_hit = 1'b1;
      if (dest_ip[31:0] == {`PTPF_V4_PFX, 8'h00, `PTPF_GRP5_LOW})
        v4_ip_hit = 1'b1;
      if (dest_ip == {`PTPF_V6_LINK, 104'h0, `PTPF_GRP5_LOW})
        v6_ip_hit = 1'b1;
    end
    // Pick the checks that belong to the frame's format
    case (format)
      `PTPF_FMT_L2: begin
        fmt_on = cfg[`PTPF_P_L2_DET]; // [RL19]
        mac_hit = l2_hit;
        ip_hit = 1'b1;
      end
      `PTPF_FMT_V4: begin
        fmt_on = cfg[`PTPF_P_V4_DET]; // [RL19]
        mac_hit = v4_mac_hit;
        ip_hit = v4_ip_hit;
      end
      `PTPF_FMT_V6: begin
        fmt_on = cfg[`PTPF_P_V6_DET]; // [RL19]
        mac_hit = v6_mac_hit;
        ip_hit = v6_ip_hit;
      end
      default: begin
        fmt_on = 1'b0;
        mac_hit = 1'b0;
        ip_hit = 1'b0;
      end
    endcase
    // Checks that are switched off always pass
    match = fmt_on && (mac_hit || !cfg[`PTPF_P_MAC_CHK]) && // [RL18] [RL20]
      (ip_hit || !cfg[`PTPF_P_IP_CHK]); // [RL18] [RL20]
  end

endmodule // ptpf_dest_match

`default_nettype wire

// ==== rtl/ptpf_top.v ====
/*
  Per-port PTP receive destination filter and pending timestamp counters,
  with a banked, port-selected register file on a plain strobe port.
  Assumes the frame path and the sent-packet strobe run on clk_sys and
  present one-cycle pulses; software keeps parse bits still while enabled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptpf_regs.vh"

module ptpf_top #(
  parameter NUM_PORTS = 3
) (
  input wire clk_sys,
  input wire rstn,
  input wire [8:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire rx_frame_valid,
  input wire [1:0] rx_frame_port,
  input wire [1:0] rx_frame_format,
  input wire [47:0] rx_dest_mac,
  input wire [127:0] rx_dest_ip,
  input wire tx_ptp_sent,
  input wire [1:0] tx_sent_port,
  output reg rx_ptp_hit,
  output reg [1:0] rx_ptp_port
);

  // Selector and software-defined address registers
  reg [2:0] bank_sel;
  reg [1:0] port_sel;
  reg [15:0] custom_dest_high;
  reg [31:0] custom_dest_low;

  // Per-port copies
  reg [14:0] parse_cfg [0:NUM_PORTS-1];
  reg [2:0] rx_pending_count [0:NUM_PORTS-1];
  reg [2:0] tx_pending_count [0:NUM_PORTS-1];

  // Decode and frame-path helpers
  reg [14:0] frame_cfg;
  reg frame_port_ok;
  reg [14:0] sel_cfg;
  reg [2:0] sel_rx_cnt;
  reg [2:0] sel_tx_cnt;
  reg sel_port_ok;
  reg [31:0] next_rdata;
  wire frame_match;
  wire rx_accept;
  wire parse_wr;
  wire ack_wr;
  wire rx_ack;
  wire tx_ack;
  integer i;

  // Configuration of the port that the current frame came in on
  always @* begin
    frame_cfg = 15'h0000;
    frame_port_ok = 1'b0;
    for (i = 0; i < NUM_PORTS; i = i + 1) begin
      if (rx_frame_port == i[1:0]) begin
        frame_cfg = parse_cfg[i];
        frame_port_ok = 1'b1;
      end
    end
  end

  // Destination matcher shared by all ports
  ptpf_dest_match u_match (
    .cfg(frame_cfg),
    .format(rx_frame_format),
    .dest_mac(rx_dest_mac),
    .dest_ip(rx_dest_ip),
    .custom_mac({custom_dest_high, custom_dest_low}),
    .match(frame_match)
  );

  // A received frame counts only when it passes the filter
  assign rx_accept = rx_frame_valid && frame_port_ok && frame_match; // [RL20]

  // Copies reached through the current port select
  always @* begin
    sel_cfg = 15'h0000;
    sel_rx_cnt = `PTPF_CNT_RESET;
    sel_tx_cnt = `PTPF_CNT_RESET;
    sel_port_ok = 1'b0;
    for (i = 0; i < NUM_PORTS; i = i + 1) begin
      if (port_sel == i[1:0]) begin // [RL6]
        sel_cfg = parse_cfg[i];
        sel_rx_cnt = rx_pending_count[i];
        sel_tx_cnt = tx_pending_count[i];
        sel_port_ok = 1'b1;
      end
    end
  end

  // Write decodes; banked registers need the matching bank
  assign parse_wr = reg_wr && reg_addr == `PTPF_OFF_PARSE &&
    bank_sel == `PTPF_BANK_PARSE; // [RL6]
  assign ack_wr = reg_wr && reg_addr == `PTPF_OFF_STAMP_ACK;
  assign rx_ack = ack_wr &&
    (|reg_wdata[`PTPF_RX_CNT_MSB:`PTPF_RX_CNT_LSB]);
  assign tx_ack = ack_wr &&
    (|reg_wdata[`PTPF_TX_CNT_MSB:`PTPF_TX_CNT_LSB]);

  // Bank, port and software-defined address registers
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bank_sel <= 3'h0;
      port_sel <= 2'h0;
      custom_dest_high <= 16'h0000;
      custom_dest_low <= 32'h00000000;
    end else if (reg_wr) begin
      case (reg_addr)
        `PTPF_OFF_BANK_PORT: begin
          bank_sel <= reg_wdata[`PTPF_BANK_MSB:`PTPF_BANK_LSB]; // [RL6]
          port_sel <= reg_wdata[`PTPF_PORT_MSB:`PTPF_PORT_LSB]; // [RL6]
        end
        `PTPF_OFF_CUSTOM_HIGH: begin
          custom_dest_high <= reg_wdata[15:0];
        end
        `PTPF_OFF_CUSTOM_LOW: begin
          custom_dest_low <= reg_wdata;
        end
        default: begin
          bank_sel <= bank_sel;
        end
      endcase
    end
  end

  // Parse configuration copies, written only for the selected port
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < NUM_PORTS; i = i + 1) begin
        parse_cfg[i] <= `PTPF_PARSE_RESET; // [RL7] [RL8] [RL9] [RL13]
      end
    end else begin
      for (i = 0; i < NUM_PORTS; i = i + 1) begin
        if (parse_wr && port_sel == i[1:0]) begin // [RL6]
          parse_cfg[i] <= reg_wdata[`PTPF_PARSE_MSB:0];
        end
      end
    end
  end

  // Receive pending counts; a hit and an acknowledge together cancel
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < NUM_PORTS; i = i + 1) begin
        rx_pending_count[i] <= `PTPF_CNT_RESET; // [RL5]
      end
    end else begin
      for (i = 0; i < NUM_PORTS; i = i + 1) begin
        if (rx_accept && rx_frame_port == i[1:0] &&
            !(rx_ack && port_sel == i[1:0])) begin
          if (rx_pending_count[i] != `PTPF_CNT_MAX)
            rx_pending_count[i] <= rx_pending_count[i] + 3'h1; // [RL4]
        end else if (rx_ack && port_sel == i[1:0] &&
            !(rx_accept && rx_frame_port == i[1:0])) begin
          if (rx_pending_count[i] != `PTPF_CNT_RESET)
            rx_pending_count[i] <= rx_pending_count[i] - 3'h1; // [RL4]
        end
      end
    end
  end

  // Transmit pending counts; same saturation and cancel as receive
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < NUM_PORTS; i = i + 1) begin
        tx_pending_count[i] <= `PTPF_CNT_RESET; // [RL5]
      end
    end else begin
      for (i = 0; i < NUM_PORTS; i = i + 1) begin
        if (tx_ptp_sent && tx_sent_port == i[1:0] &&
            !(tx_ack && port_sel == i[1:0])) begin
          if (tx_pending_count[i] != `PTPF_CNT_MAX)
            tx_pending_count[i] <= tx_pending_count[i] + 3'h1; // [RL2]
        end else if (tx_ack && port_sel == i[1:0] &&
            !(tx_ptp_sent && tx_sent_port == i[1:0])) begin
          if (tx_pending_count[i] != `PTPF_CNT_RESET)
            tx_pending_count[i] <= tx_pending_count[i] - 3'h1; // [RL2]
        end
      end
    end
  end

  // Read data; unmapped, wrong bank or absent port reads zero
  always @* begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `PTPF_OFF_BANK_PORT: begin
        next_rdata[`PTPF_BANK_MSB:`PTPF_BANK_LSB] = bank_sel;
        next_rdata[`PTPF_PORT_MSB:`PTPF_PORT_LSB] = port_sel;
      end
      `PTPF_OFF_CUSTOM_HIGH: begin
        next_rdata[15:0] = custom_dest_high;
      end
      `PTPF_OFF_CUSTOM_LOW: begin
        next_rdata = custom_dest_low;
      end
      `PTPF_OFF_PARSE: begin
        if (bank_sel == `PTPF_BANK_PARSE && sel_port_ok)
          next_rdata[`PTPF_PARSE_MSB:0] = sel_cfg;
      end
      `PTPF_OFF_CAP_INFO: begin
        // Reserved bits 31:7 and 3 stay zero
        if (bank_sel == `PTPF_BANK_CAP && sel_port_ok) begin // [RL5]
          next_rdata[`PTPF_TX_CNT_MSB:`PTPF_TX_CNT_LSB] = sel_tx_cnt; // [RL1]
          next_rdata[`PTPF_RX_CNT_MSB:`PTPF_RX_CNT_LSB] = sel_rx_cnt; // [RL3]
        end
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // Read data register: valid the cycle after the read strobe only
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Qualified frame indication toward the timestamp capture
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_ptp_hit <= 1'b0;
      rx_ptp_port <= 2'h0;
    end else begin
      rx_ptp_hit <= rx_accept;
      if (rx_accept)
        rx_ptp_port <= rx_frame_port;
    end
  end

endmodule // ptpf_top

`default_nettype wire

// ==== dv/ptpf_monitor.sv ====
/* Checker for ptpf_top read data and frame accept outputs.
   Assumes a single clk_sys domain and active-low asynchronous rstn. */
`timescale 1ns/1ps
`default_nettype none
module ptpf_monitor #(
  parameter NUM_PORTS = 3
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [8:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rx_frame_valid,
  input wire logic [1:0] rx_frame_port,
  input wire logic [1:0] rx_frame_format,
  input wire logic rx_ptp_hit,
  input wire logic [1:0] rx_ptp_port
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Steps of a capture read and of a refused frame
  sequence s_cap_rd;
    reg_rd && reg_addr == 9'h160;
  endsequence
  sequence s_bad_frame;
    rx_frame_valid && (rx_frame_format == 2'h0 || rx_frame_port >= NUM_PORTS);
  endsequence
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero without a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 9'h100 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_cap_resv: assert property (s_cap_rd |=> reg_rdata[31:7] == 25'h0 && !reg_rdata[3])
    else $error("capture reserved bits set");
  chk_rdata_once: assert property (s_cap_rd ##1 !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data stood too long");
  chk_refused: assert property (s_bad_frame |=> !rx_ptp_hit)
    else $error("refused frame accepted");
  chk_hit_cause: assert property (rx_ptp_hit |-> $past(rx_frame_valid))
    else $error("hit without frame");
  chk_hit_port: assert property (rx_ptp_hit |-> rx_ptp_port == $past(rx_frame_port))
    else $error("hit port wrong");
  chk_port_hold: assert property (!rx_ptp_hit |-> $stable(rx_ptp_port))
    else $error("hit port moved without hit");
endmodule // ptpf_monitor
bind ptpf_top ptpf_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (
  .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_frame_valid(rx_frame_valid),
  .rx_frame_port(rx_frame_port), .rx_frame_format(rx_frame_format),
  .rx_ptp_hit(rx_ptp_hit), .rx_ptp_port(rx_ptp_port));
`default_nettype wire

// ==== dv/ptpf_frame_src.sv ====
/* Frame path model: builds a receive descriptor from table indices.
   Assumes the bench holds req high for one clk_sys cycle per frame. */
`timescale 1ns/1ps
`default_nettype none
module ptpf_frame_src (
  input wire logic req,
  input wire logic [1:0] port,
  input wire logic [1:0] fmt,
  input wire logic [2:0] mac_sel,
  input wire logic [2:0] ip_sel,
  input wire logic [47:0] custom,
  output logic rx_frame_valid,
  output logic [1:0] rx_frame_port,
  output logic [1:0] rx_frame_format,
  output logic [47:0] rx_dest_mac,
  output logic [127:0] rx_dest_ip
);
  logic [47:0] mac;
  logic [127:0] ip;
  // Low group word; 5 and above give an address outside the groups
  function automatic logic [15:0] grp(input logic [2:0] k);
    grp = k < 3'h4 ? 16'h0181 + k : (k == 3'h4 ? 16'h006b : 16'h0199); // Groups
  endfunction
  // Destination addresses per format
  always_comb begin
    case (fmt)
      2'h1: mac = mac_sel == 3'h0 ? 48'h0180c200000e // Layer 2 A
        : mac_sel == 3'h1 ? 48'h011b19000000 // Layer 2 B
        : mac_sel == 3'h2 ? custom : 48'h020000000001; // Custom
      2'h2: mac = mac_sel == 3'h5 ? custom
        : {24'h01005e, 8'h00, grp(mac_sel)}; // IPv4 group MAC
      default: mac = mac_sel == 3'h5 ? custom
        : {32'h33330000, grp(mac_sel)}; // IPv6 group MAC
    endcase
    ip = fmt == 2'h2 ? {96'h0, 16'he000, grp(ip_sel)}
      : {16'hff02, 96'h0, grp(ip_sel)};
  end
  // Released lines show the inverse of the last value
  assign rx_frame_valid = req;
  assign rx_frame_port = req ? port : ~port;
  assign rx_frame_format = req ? fmt : ~fmt;
  assign rx_dest_mac = req ? mac : ~mac;
  assign rx_dest_ip = req ? ip : ~ip;
endmodule // ptpf_frame_src
`default_nettype wire

// ==== dv/testbench.sv ====
/* Self-checking bench for ptpf_top with a model of counts and filter.
   Assumes one 20 MHz clock and the frame source model beside it. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, rstn, reg_wr, reg_rd, tx_ptp_sent, req, rx_ptp_hit;
  logic rx_frame_valid;
  logic [8:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, rd_val, r;
  logic [1:0] tx_sent_port, f_port, f_fmt, rx_ptp_port;
  logic [1:0] rx_frame_port, rx_frame_format;
  logic [2:0] f_mac, f_ip;
  logic [47:0] rx_dest_mac;
  logic [127:0] rx_dest_ip;
  logic [14:0] cfg [4];
  int rxc [4], txc [4];
  int fails, n_checks;
  localparam logic [47:0] custom_mac = 48'h02aabbccddee;
  ptpf_top #(.NUM_PORTS(3)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_frame_valid(rx_frame_valid),
    .rx_frame_port(rx_frame_port), .rx_frame_format(rx_frame_format),
    .rx_dest_mac(rx_dest_mac), .rx_dest_ip(rx_dest_ip),
    .tx_ptp_sent(tx_ptp_sent), .tx_sent_port(tx_sent_port),
    .rx_ptp_hit(rx_ptp_hit), .rx_ptp_port(rx_ptp_port));
  ptpf_frame_src src_u (
    .req(req), .port(f_port), .fmt(f_fmt), .mac_sel(f_mac), .ip_sel(f_ip),
    .custom(custom_mac), .rx_frame_valid(rx_frame_valid),
    .rx_frame_port(rx_frame_port), .rx_frame_format(rx_frame_format),
    .rx_dest_mac(rx_dest_mac), .rx_dest_ip(rx_dest_ip));
  // Clock at 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic sel(input logic [2:0] b, input int p);
    wr(9'h154, {26'h0, p[1:0], 1'b0, b});
  endtask
  task automatic cap(input int p);
    sel(3'h0, p);
    rd(9'h160);
    chk(rd_val, {25'h0, txc[p][2:0], 1'b0, rxc[p][2:0]}); // Counts
  endtask
  task automatic cfg_wr(input int p, input logic [31:0] d);
    sel(3'h1, p);
    wr(9'h158, d); // Parse bits written with the stamp unit idle
    cfg[p] = d[14:0];
    rd(9'h158);
    chk(rd_val[14:0], d[14:0]); // Parse readback
  endtask
  task automatic ack(input int p, input logic [31:0] d);
    sel(3'h0, p);
    wr(9'h128, d);
    if (d[2:0] != 3'h0 && rxc[p] > 0) rxc[p]--; // Receive ack
    if (d[6:4] != 3'h0 && txc[p] > 0) txc[p]--; // Transmit ack
  endtask
  task automatic tx(input int p, input int n);
    @(posedge clk_sys);
    tx_ptp_sent <= 1'b1;
    tx_sent_port <= p[1:0];
    repeat (n) @(posedge clk_sys);
    tx_ptp_sent <= 1'b0;
    txc[p] = txc[p] + n > 7 ? 7 : txc[p] + n; // Sent packets
  endtask
  function automatic logic acc(input int p, f, g, i);
    logic [14:0] c;
    logic mok;
    c = cfg[p];
    if (p > 2 || f == 0 || !c[f == 1 ? 2 : f == 2 ? 0 : 1]) return 1'b0; // Detect
    if (f == 1) begin
      mok = (g == 0 && c[14]) || (g == 1 && c[13]) || (g == 2 && c[7]); // L2
      return !c[3] || mok; // MAC
    end
    mok = (g < 5 && c[12 - g]) || (g == 5 && c[f == 2 ? 5 : 6]); // MAC
    return (!c[3] || mok) && (!c[4] || (i < 5 && c[12 - i])); // IP
  endfunction
  task automatic frame(input int p, f, g, i);
    logic e;
    e = acc(p, f, g, i);
    @(posedge clk_sys);
    req <= 1'b1;
    f_port <= p[1:0];
    f_fmt <= f[1:0];
    f_mac <= g[2:0];
    f_ip <= i[2:0];
    @(posedge clk_sys);
    req <= 1'b0;
    #1 chk(rx_ptp_hit, e); // Accept decision
    if (e) begin
      chk(rx_ptp_port, p[1:0]); // Hit port
      if (rxc[p] < 7) rxc[p]++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    conclude();
  end
  // Main sequence
  initial begin
    seed = 32'h9d0a9aff;
    fails = 0;
    n_checks = 0;
    {rstn, reg_wr, reg_rd, tx_ptp_sent, req} = 5'h0;
    {reg_addr, reg_wdata, tx_sent_port, f_port, f_fmt, f_mac, f_ip} = 0;
    for (int p = 0; p < 4; p++) begin
      cfg[p] = 15'h711f;
      rxc[p] = 0;
      txc[p] = 0;
    end
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      sel(3'h1, p);
      rd(9'h158);
      chk(rd_val, p < 3 ? 32'h711f : 32'h0); // Reset enables
      rd(9'h160);
      chk(rd_val, 32'h0); // Capture info outside bank 0
      cap(p); // Counts reset
    end
    rd(9'h100);
    chk(rd_val, 32'h0); // Unmapped place
    sel(3'h0, 0);
    wr(9'h160, 32'hffffffff);
    cap(0); // Read-only capture info
    wr(9'h120, {16'h0, custom_mac[47:32]});
    wr(9'h124, custom_mac[31:0]);
    rd(9'h120);
    chk(rd_val, {16'h0, custom_mac[47:32]}); // Custom high readback
    rd(9'h124);
    chk(rd_val, custom_mac[31:0]); // Custom low readback
    tx(1, 9);
    cap(1);
    rd(9'h154);
    chk(rd_val, 32'h10); // Bank and port select readback
    rd(9'h128);
    chk(rd_val, 32'h0); // Acknowledge place reads zero
    repeat (8) ack(1, 32'h10);
    cap(1);
    for (int k = 0; k < 2; k++) begin
      cfg_wr(0, k ? 32'h7fff : 32'h711f);
      for (int f = 0; f < 4; f++)
        for (int g = 0; g < 7; g++)
          frame(0, f, g, g);
      cap(0);
    end
    for (int n = 0; n < 400; n++) begin
      r = rnd();
      case (r[2:0])
        3'h0: cfg_wr(r[4:3] % 3, rnd());
        3'h1, 3'h2, 3'h3: frame(r[4:3], r[6:5], r[10:8] % 7, r[14:12] % 7);
        3'h4: tx(r[4:3] % 3, 1 + r[6:5]);
        3'h5: ack(r[4:3] % 3, rnd());
        default: cap(r[4:3]);
      endcase
    end
    conclude();
  end
endmodule // testbench
`default_nettype wire
